// file: hdl/sef_spi_front.sv
`timescale 1ns/1ns
// How it works
// - bytes arrive most significant bit first
// - first bit taken at first rising edge
// - output bytes leave most significant bit first
// - read data starts on first following falling edge
// - output changes only on falling clock edges
// - deselected means output high impedance
// - select low makes the device active
// - nothing accepted before a select falling edge
// - pause freezes transfer without deselecting
// - paused: output off, clock and input ignored
// - write protect freezes the block protect bits
// - bad opcode: standby until select rises
// - good opcode: active until select rises
// - works in clock modes 0 and 3
module sef_spi_front #(
   parameter int NUM_OPC = sef_pkg::MAX_OPC // opcode slots in use
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic hold_n,
   input wire logic wp_n,
   output logic miso,
   output logic miso_oe
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (NUM_OPC < 1 || NUM_OPC > sef_pkg::MAX_OPC) begin : g_bad_opc
      $error("NUM_OPC must lie between 1 and 4");
   end

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [31:0] opc_tab_q;                 // opcode per slot
   logic [NUM_OPC-1:0] opc_en_q;           // slot enabled
   logic [NUM_OPC-1:0] opc_rd_q;           // slot is read-type
   logic [7:0] tx_q;                       // byte returned on reads
   sef_pkg::sef_prot_s prot_q;             // block protect pair
   sef_pkg::sef_state_e st_q;              // link decode state
   sef_pkg::sef_state_e st_d;
   logic [2:0] bit_cnt_q;                  // bit within byte
   logic [7:0] byte_cnt_q;                 // bytes this frame, saturating
   logic [6:0] shift_q;                    // partial input byte
   logic armed_q;                          // select fall seen since reset
   logic [7:0] rx_hold_q;                  // byte handed to bus side
   logic rx_tgl_q;                         // flips once per handed byte
   logic miso_q;                           // output bit
   logic oe_q;                             // output driven
   logic [7:0] txs_q;                      // output shifter
   logic [NUM_OPC-1:0] hit;                // opcode matches a slot
   logic [NUM_OPC-1:0] hit_rd;             // match on a read slot
   sef_pkg::sef_link_s link_raw;
   sef_pkg::sef_link_s link_s1_q;          // first sync stage only
   sef_pkg::sef_link_s link_s2_q;
   logic rx_s1_q, rx_s2_q, rx_s3_q;        // toggle synchroniser plus edge
   logic wp_s1_q, wp_s2_q;                 // write protect synchroniser
   logic [7:0] rx_data_q;                  // last byte seen by software
   logic rx_flag_q;                        // fresh byte not yet read
   logic [7:0] rx_cnt_q;                   // bytes seen by software
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // ----------------------------------------------------------------
   // link side: input decode on rising edges
   // ----------------------------------------------------------------
   // rising edges count only when not paused, armed and not in standby
   wire take = hold_n & armed_q & (st_q != sef_pkg::ST_STANDBY);
   wire byte_done = take & (bit_cnt_q == 3'd7);
   wire [7:0] in_byte = {shift_q, mosi}; // earlier bits sit higher
   wire wp_on = ~wp_s2_q;               // write protect asserted low

   // one comparator per opcode slot
   for (genvar g = 0; g < NUM_OPC; g++) begin : g_slot
      assign hit[g] = opc_en_q[g] & (opc_tab_q[8*g +: 8] == in_byte);
      assign hit_rd[g] = hit[g] & opc_rd_q[g];
   end

   // next state once the opcode byte is complete
   always_comb begin
      st_d = st_q;
      if (byte_done && st_q == sef_pkg::ST_OPCODE) begin
         if (|hit_rd) begin
            st_d = sef_pkg::ST_READ;      // active until select rises
         end else if (|hit) begin
            st_d = sef_pkg::ST_WRITE;     // active until select rises
         end else begin
            st_d = sef_pkg::ST_STANDBY;   // unknown opcode
         end
      end
   end

   // select high holds counters clear; low releases them
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         st_q <= sef_pkg::ST_OPCODE;
         bit_cnt_q <= 3'd0;
         shift_q <= 7'h00;
         byte_cnt_q <= 8'h00;
      end else if (take) begin // sampled on rising edges only
         bit_cnt_q <= bit_cnt_q + 3'd1;
         shift_q <= in_byte[6:0]; // shifts left, msb first
         st_q <= st_d;
         if (byte_done && byte_cnt_q != 8'hff) begin
            byte_cnt_q <= byte_cnt_q + 8'h01;
         end
      end
   end

   // completed bytes go to the bus side with a toggle; held for 8 edges
   always_ff @(posedge sclk or negedge presetn) begin
      if (!presetn) begin
         rx_hold_q <= 8'h00;
         rx_tgl_q <= 1'b0;
      end else if (byte_done) begin
         rx_hold_q <= in_byte;
         rx_tgl_q <= ~rx_tgl_q;
      end
   end

   // select falling edge arms the decoder after power-up
   always_ff @(negedge cs_n or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // link side: output on falling edges
   // ----------------------------------------------------------------
   // deselect or pause drops the drive at once, without a clock edge
   wire oe_kill = cs_n | ~hold_n;

   // drive enable follows read state; cleared by select or pause
   always_ff @(negedge sclk or posedge oe_kill) begin
      if (oe_kill) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= (st_q == sef_pkg::ST_READ); // standby never drives
      end
   end

   // shifter keeps its place through a pause, so the byte resumes
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         miso_q <= 1'b0;
         txs_q <= 8'h00;
      end else if (hold_n && st_q == sef_pkg::ST_READ) begin
         if (bit_cnt_q == 3'd0) begin
            miso_q <= tx_q[7];  // first falling edge after a byte
            txs_q <= {tx_q[6:0], 1'b0};
         end else begin
            miso_q <= txs_q[7];
            txs_q <= {txs_q[6:0], 1'b0};
         end
      end
   end

   assign miso = miso_q;
   assign miso_oe = oe_q;

   // ----------------------------------------------------------------
   // crossings into the bus clock
   // ----------------------------------------------------------------
   assign link_raw.armed = armed_q;
   assign link_raw.reading = (st_q == sef_pkg::ST_READ);
   assign link_raw.standby = (st_q == sef_pkg::ST_STANDBY);
   assign link_raw.selected = ~cs_n;

   // status levels and write protect pass two flops; toggle gets a third
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_s1_q <= '0;
         link_s2_q <= '0;
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
         rx_s3_q <= 1'b0;
         wp_s1_q <= 1'b1;
         wp_s2_q <= 1'b1;
      end else begin
         link_s1_q <= link_raw;
         link_s2_q <= link_s1_q;
         rx_s1_q <= rx_tgl_q;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
         wp_s1_q <= wp_n; // pin assumed steady across writes
         wp_s2_q <= wp_s1_q;
      end
   end

   wire rx_new = rx_s2_q ^ rx_s3_q; // one pulse per handed byte

   // ----------------------------------------------------------------
   // apb slave: decode
   // ----------------------------------------------------------------
   wire setup = psel & ~penable;
   wire done = psel & penable & pready_q;   // completing edge
   wire sel_tab = (paddr == sef_pkg::OFS_OPC_TABLE);
   wire sel_cfg = (paddr == sef_pkg::OFS_OPC_CFG);
   wire sel_tx = (paddr == sef_pkg::OFS_TX_DATA);
   wire sel_prot = (paddr == sef_pkg::OFS_PROTECT);
   wire sel_rx = (paddr == sef_pkg::OFS_RX_DATA);
   wire sel_st = (paddr == sef_pkg::OFS_STATUS);
   wire mapped = sel_tab | sel_cfg | sel_tx | sel_prot | sel_rx | sel_st;
   wire wr = done & pwrite;
   wire rx_read = done & ~pwrite & sel_rx;

   // read words, unused bits zero
   wire [31:0] cfg_word = (32'(opc_en_q) << sef_pkg::CFG_EN_LSB) | (32'(opc_rd_q) << sef_pkg::CFG_RD_LSB);
   wire [31:0] rx_word = {23'h0, rx_flag_q, rx_data_q};
   wire [31:0] st_word = {16'h0, rx_cnt_q, 3'h0,
                          link_s2_q.armed, wp_on, link_s2_q.reading, link_s2_q.standby, link_s2_q.selected};
   wire [31:0] rd_mux = sel_tab ? opc_tab_q :
                        sel_cfg ? cfg_word :
                        sel_tx ? {24'h0, tx_q} :
                        sel_prot ? {30'h0, prot_q} :
                        sel_rx ? rx_word :
                        sel_st ? st_word : 32'h0;

   // ----------------------------------------------------------------
   // apb slave: answer one access cycle after setup
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~mapped; // unmapped offsets error
         if (setup) begin
            prdata_q <= pwrite ? 32'h0 : rd_mux;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ----------------------------------------------------------------
   // apb slave: writable registers
   // ----------------------------------------------------------------
   // opcode table and tx byte are read by the link clock as is:
   // change them only while the device is deselected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opc_tab_q <= sef_pkg::RST_OPC_TABLE;
         opc_en_q <= sef_pkg::RST_OPC_CFG[sef_pkg::CFG_EN_LSB +: NUM_OPC];
         opc_rd_q <= sef_pkg::RST_OPC_CFG[sef_pkg::CFG_RD_LSB +: NUM_OPC];
         tx_q <= sef_pkg::RST_TX_DATA;
         prot_q <= sef_pkg::RST_PROTECT;
      end else if (wr) begin
         if (sel_tab) begin
            opc_tab_q <= pwdata;
         end
         if (sel_cfg) begin
            opc_en_q <= pwdata[sef_pkg::CFG_EN_LSB +: NUM_OPC];
            opc_rd_q <= pwdata[sef_pkg::CFG_RD_LSB +: NUM_OPC];
         end
         if (sel_tx) begin
            tx_q <= pwdata[7:0];
         end
         if (sel_prot && !wp_on) begin // frozen while protected
            prot_q <= pwdata[1:0];
         end
      end
   end

   // received byte; a new byte beats a clearing read in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data_q <= 8'h00;
         rx_flag_q <= 1'b0;
         rx_cnt_q <= 8'h00;
      end else if (rx_new) begin
         rx_data_q <= rx_hold_q; // stable: next change is 8 link edges away
         rx_flag_q <= 1'b1;
         rx_cnt_q <= rx_cnt_q + 8'h01;
      end else if (rx_read) begin
         rx_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_rx_msb_first: assert property (
      @(posedge sclk) disable iff (cs_n || !presetn)
      byte_done |=> (rx_hold_q[0] == $past(mosi)) && (rx_hold_q[7:1] == $past(shift_q)))
      else $error("received byte not assembled msb first");

   a_first_bit_taken: assert property (
      @(posedge sclk) disable iff (cs_n)
      (armed_q && hold_n && byte_cnt_q == 8'h00 && bit_cnt_q == 3'd0) |=> bit_cnt_q == 3'd1)
      else $error("first rising edge after select did not take a bit");

   a_tx_msb_first: assert property (
      @(negedge sclk) disable iff (cs_n || !hold_n)
      (st_q == sef_pkg::ST_READ && bit_cnt_q == 3'd0) |=> ##0 (miso_q == $past(tx_q[7])))
      else $error("read byte did not start with its msb");

   a_read_drive_start: assert property (
      @(negedge sclk) disable iff (oe_kill)
      (st_q == sef_pkg::ST_READ && byte_cnt_q == 8'h01 && bit_cnt_q == 3'd0) |=> oe_q)
      else $error("output not driven on first falling edge after opcode");

   // sampled sclk high at an edge event means a falling edge: the output must
   // not have moved since the rising edge before it
   a_out_rise_stable: assert property (
      @(sclk) disable iff (cs_n)
      sclk |-> $stable(miso_q))
      else $error("output changed on a rising edge");

   a_deselect_hiz: assert property (
      @(posedge pclk) disable iff (!presetn)
      cs_n |-> !miso_oe)
      else $error("output driven while deselected");

   a_unarmed_idle: assert property (
      @(posedge sclk) disable iff (cs_n)
      !armed_q |=> (bit_cnt_q == 3'd0) && (st_q == sef_pkg::ST_OPCODE))
      else $error("link decoded before select falling edge");

   a_pause_hiz: assert property (
      @(posedge pclk) disable iff (!presetn)
      !hold_n |-> !miso_oe)
      else $error("output driven while paused");

   a_protect_frozen: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wp_on && wr && sel_prot) |=> $stable(prot_q))
      else $error("protect bits changed under write protect");

   a_standby_stays: assert property (
      @(posedge sclk) disable iff (cs_n)
      (st_q == sef_pkg::ST_STANDBY) |=> (st_q == sef_pkg::ST_STANDBY) && !oe_q)
      else $error("standby left or output driven before deselect");

   a_apb_answer: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready_q ##1 !pready_q)
      else $error("apb answer not exactly one access cycle");

endmodule

// file: hdl/sef_pkg.sv
// ----------------------------------------------------------------
// shared constants and carriers of the serial front end
// ----------------------------------------------------------------
package sef_pkg;

   // ----------------------------------------------------------------
   // register byte offsets on the apb slave
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_OPC_TABLE = 8'h00; // one opcode per byte lane
   localparam logic [7:0] OFS_OPC_CFG = 8'h04;   // slot enable and read-type bits
   localparam logic [7:0] OFS_TX_DATA = 8'h08;   // byte shifted out on reads
   localparam logic [7:0] OFS_PROTECT = 8'h0c;   // block protect pair
   localparam logic [7:0] OFS_RX_DATA = 8'h10;   // last byte taken from the link
   localparam logic [7:0] OFS_STATUS = 8'h14;    // live link and pin state

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MAX_OPC = 4;       // slots that fit the table word
   localparam int CFG_EN_LSB = 0;    // enable bits start here
   localparam int CFG_RD_LSB = 4;    // read-type bits start here
   localparam int RX_NEW_BIT = 8;    // fresh-byte flag in rx word
   localparam int ST_SEL_BIT = 0;    // device selected
   localparam int ST_STBY_BIT = 1;   // standby after a bad opcode
   localparam int ST_READ_BIT = 2;   // read-type transfer running
   localparam int ST_WP_BIT = 3;     // write protect pin asserted
   localparam int ST_ARMED_BIT = 4;  // select falling edge seen
   localparam int ST_CNT_LSB = 8;    // received byte count
   localparam int BYTE_W = 8;        // bits per link byte

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_OPC_TABLE = 32'h0000_0000;
   localparam logic [7:0] RST_OPC_CFG = 8'h00;
   localparam logic [7:0] RST_TX_DATA = 8'h00;
   localparam logic [1:0] RST_PROTECT = 2'h0;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_OPCODE,
      ST_READ,
      ST_WRITE,
      ST_STANDBY
   } sef_state_e;

   // levels that cross from the link side to the bus side
   typedef struct packed {
      logic armed;
      logic reading;
      logic standby;
      logic selected;
   } sef_link_s;

   // block protect pair, frozen while write protect is asserted
   typedef struct packed {
      logic block_protect_hi;
      logic block_protect_lo;
   } sef_prot_s;

endpackage

// file: sim/sef_spi_master_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// serial bus master model: select, clock, data and side pins
// ----------------------------------------------------------------
module sef_spi_master_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   output logic hold_n,
   output logic wp_n,
   input wire logic miso,
   input wire logic miso_oe
);
   logic mode3 = 1'b0; // idle clock level of this frame
   int oe_bits = 0;    // bits taken while output was driven

   // lines at rest; side pins always at a definite level
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      hold_n = 1'b1;
      wp_n = 1'b1;
   end

   // clock parked at the mode level before select falls; the fall arms the device
   task automatic select(input logic m3);
      mode3 = m3;
      sclk = m3;
      #37;
      cs_n = 1'b0;
      #63;
   endtask

   // first nb bits of d, msb first; output taken at rising edges
   task automatic xfer(input logic [7:0] d, input int nb, output logic [7:0] r);
      r = 8'h00;
      for (int i = 0; i < nb; i++) begin
         sclk = 1'b0;
         mosi = d[7 - i];
         #63;
         sclk = 1'b1;
         // an undriven line must never pass for data
         r = {r[6:0], miso_oe ? miso : 1'bx};
         if (miso_oe === 1'b1) oe_bits++;
         #62;
      end
      mosi = ~mosi; // stale bit not left on the line
   endtask

   // clock back to idle low in mode 0 only (mode 3 leaves it as is), then select released
   task automatic deselect();
      if (!mode3) sclk = 1'b0;
      #63;
      cs_n = 1'b1;
      #100;
   endtask

   // pause only while selected, clock low at both pause edges; junk clocks meanwhile
   task automatic pause(input logic [7:0] junk, output logic oe_seen);
      sclk = 1'b0;
      #30;
      hold_n = 1'b0;
      #30;
      oe_seen = miso_oe;
      for (int i = 0; i < 8; i++) begin
         mosi = junk[i];
         #62 sclk = ~sclk;
      end
      #30;
      hold_n = 1'b1;
      #30;
   endtask

   // only called between frames, so it is steady through writes
   task automatic set_wp(input logic v);
      wp_n = v;
   endtask
endmodule

// file: sim/sef_spi_front_bench.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// self-checking bench of the serial front end
// ----------------------------------------------------------------
module sef_spi_front_bench;
   typedef struct {
      logic [31:0] data;
      logic [31:0] mask;
      logic err;
   } sef_note_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic sclk, cs_n, mosi, hold_n, wp_n, miso, miso_oe, oe;
   logic [7:0] tx, r;
   sef_note_s notes[$]; // expected read answers, oldest first
   sef_note_s cur;
   int miscompares = 0;
   int samples_checked = 0;
   int cnt = 0; // bytes the device should have counted
   int ob;

   sef_spi_front u_sef_spi_front (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n), .wp_n(wp_n),
      .miso(miso), .miso_oe(miso_oe));
   sef_spi_master_model u_sef_spi_master_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .hold_n(hold_n), .wp_n(wp_n), .miso(miso), .miso_oe(miso_oe));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // status word expected; armed always set once a frame was seen
   function automatic logic [31:0] st(input logic sel, input logic sb, input logic rg, input logic wp, input int c);
      logic [31:0] v;
      v = 32'h0;
      v[sef_pkg::ST_SEL_BIT] = sel;
      v[sef_pkg::ST_STBY_BIT] = sb;
      v[sef_pkg::ST_READ_BIT] = rg;
      v[sef_pkg::ST_WP_BIT] = wp;
      v[sef_pkg::ST_ARMED_BIT] = 1'b1;
      v[sef_pkg::ST_CNT_LSB +: 8] = 8'(c);
      return v;
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= we;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         check("apb ready", 32'h1, 32'h0);
         conclude();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0,
         input logic [31:0] m = 32'hffffffff);
      notes.push_back('{e, m, err});
      apb(1'b0, a, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // clock, watchdog and read monitor
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // a hang counts as a mismatch
   initial begin
      #2000000;
      check("run time", 32'h0, 32'h1);
      conclude();
   end

   // read data taken at the completing edge only
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         cur = notes.pop_front();
         check("apb read data", cur.data, prdata & cur.mask);
         check("apb error flag", {31'h0, cur.err}, {31'h0, pslverr});
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      seed = 32'hfb4471be;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, then an unmapped offset
      for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
      rd(8'h18, 32'h0, 1'b1);
      wr(sef_pkg::OFS_OPC_TABLE, 32'h00050203);
      wr(sef_pkg::OFS_OPC_CFG, 32'h00000057);
      // partial opcode dropped at deselect; later frames decode afresh
      u_sef_spi_master_model.select(1'b0);
      u_sef_spi_master_model.xfer(8'h03, 5, r);
      u_sef_spi_master_model.deselect();
      // both clock modes, both read opcodes, pause at the end
      for (int m = 0; m < 2; m++) begin
         seed = lfsr(seed);
         tx = seed[7:0];
         wr(sef_pkg::OFS_TX_DATA, seed);
         rd(sef_pkg::OFS_TX_DATA, {24'h0, tx});
         u_sef_spi_master_model.select(m[0]);
         u_sef_spi_master_model.xfer(m[0] ? 8'h05 : 8'h03, 8, r);
         u_sef_spi_master_model.xfer(seed[15:8], 8, r);
         check("miso first byte", {24'h0, tx}, {24'h0, r});
         cnt += 2;
         repeat (6) @(posedge pclk);
         rd(sef_pkg::OFS_STATUS, st(1, 0, 1, 0, cnt));
         u_sef_spi_master_model.xfer(seed[23:16], 8, r);
         check("miso second byte", {24'h0, tx}, {24'h0, r});
         cnt++;
         u_sef_spi_master_model.pause(seed[31:24], oe);
         check("miso drive in pause", 32'h0, {31'h0, oe});
         u_sef_spi_master_model.deselect();
         check("miso drive deselected", 32'h0, {31'h0, miso_oe});
         repeat (6) @(posedge pclk);
         rd(sef_pkg::OFS_RX_DATA, {23'h0, 1'b1, seed[23:16]});
         rd(sef_pkg::OFS_STATUS, st(0, 0, 0, 0, cnt));
      end
      // write opcode split by a pause with junk clocks
      ob = u_sef_spi_master_model.oe_bits;
      seed = lfsr(seed);
      u_sef_spi_master_model.select(1'b0);
      u_sef_spi_master_model.xfer(8'h02, 4, r);
      u_sef_spi_master_model.pause(8'h5a, oe);
      u_sef_spi_master_model.xfer(8'h20, 4, r);
      u_sef_spi_master_model.xfer(seed[7:0], 8, r);
      u_sef_spi_master_model.deselect();
      cnt += 2;
      check("miso drive in write", 32'(ob), 32'(u_sef_spi_master_model.oe_bits));
      repeat (6) @(posedge pclk);
      rd(sef_pkg::OFS_RX_DATA, {23'h0, 1'b1, seed[7:0]});
      rd(sef_pkg::OFS_STATUS, st(0, 0, 0, 0, cnt));
      // protect pair frozen only while write protect is asserted
      wr(sef_pkg::OFS_PROTECT, 32'h3);
      rd(sef_pkg::OFS_PROTECT, 32'h3);
      u_sef_spi_master_model.set_wp(1'b0);
      repeat (4) @(posedge pclk);
      wr(sef_pkg::OFS_PROTECT, 32'h0);
      rd(sef_pkg::OFS_PROTECT, 32'h3);
      rd(sef_pkg::OFS_STATUS, st(0, 0, 0, 1, cnt));
      u_sef_spi_master_model.set_wp(1'b1);
      repeat (4) @(posedge pclk);
      wr(sef_pkg::OFS_PROTECT, 32'h2);
      rd(sef_pkg::OFS_PROTECT, 32'h2);
      // unknown opcode: standby, a valid opcode after it is ignored
      ob = u_sef_spi_master_model.oe_bits;
      u_sef_spi_master_model.select(1'b0);
      u_sef_spi_master_model.xfer(8'h9a, 8, r);
      u_sef_spi_master_model.xfer(8'h03, 8, r);
      u_sef_spi_master_model.xfer(8'h00, 8, r);
      repeat (6) @(posedge pclk);
      rd(sef_pkg::OFS_STATUS, st(1, 1, 0, 0, 0), 1'b0, 32'h0000001f);
      u_sef_spi_master_model.deselect();
      check("miso drive in standby", 32'(ob), 32'(u_sef_spi_master_model.oe_bits));
      // standby ends when select rises; the next frame reads again
      u_sef_spi_master_model.select(1'b1);
      u_sef_spi_master_model.xfer(8'h05, 8, r);
      u_sef_spi_master_model.xfer(8'hff, 8, r);
      check("miso after standby", {24'h0, tx}, {24'h0, r});
      u_sef_spi_master_model.deselect();
      repeat (4) @(posedge pclk);
      conclude();
   end
endmodule
